// File: design/pfd_top.sv
// Purpose: programmable frequency divider with APB registers
// Assumes: APB3 slave, zero wait states
// Notes: output pin shared with general output by a strap input
`timescale 1ns/1ps
`default_nettype none
`include "pfd_params.svh"
// Operation
// [RULE1] A prescaler divides the source and a general counter runs on it.
// [RULE2] Two control bits choose the prescale ratio.
// [RULE3] An 8-bit read/write value register sets the counter reload.
// [RULE4] A control bit picks 3.58 MHz over four or the 32768 Hz source.
// [RULE5] The enable bit starts the divider and drives its output.
// [RULE6] Value writes are ignored while the divider is disabled.
// [RULE7] Hardware clears the value register while disabled.
// [RULE8] Output frequency is prescaler rate over 2 times (N plus 1).
// [RULE9] A fixed option routes the pin to plain output or divider output.
// [RULE10] A toggle flop flips every N plus 1 prescale pulses, low when off.
module pfd_top (
    input wire logic CORE_CLK, // core clock
    input wire logic NRST, // async reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb enable
    input wire logic PWRITE, // apb direction
    input wire logic [11:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error
    input wire logic PIN_MODE_DIVIDER, // fixed option, 1 = divider out
    input wire logic GPIO_OUT, // ordinary output level
    output logic PIN_OUT // shared output pin
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    // register state and next values
    pfd_pkg::pfd_ctrl_type ctrl;
    pfd_pkg::pfd_ctrl_type next_ctrl;
    pfd_pkg::pfd_state_type state;
    pfd_pkg::pfd_state_type next_state;
    logic [7:0] divider_value;
    logic [7:0] next_divider_value;

    // counters, pulses and the output wave
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [2:0] pres_cnt;
    logic [2:0] next_pres_cnt;
    logic src_tick;
    logic pres_tick;
    logic next_pres_tick;
    logic wave;
    logic next_wave;
    logic pres_hit;
    logic [7:0] pres_max;
    logic cnt_hit;
    logic running;

    // bus decode
    logic setup;
    logic access;
    logic rd_setup;
    logic wr_ctrl;
    logic wr_value;
    logic hit_ctrl;
    logic hit_value;
    logic hit_any;
    logic [31:0] next_rdata;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic next_pin;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // prescale ratio 1, 2, 4 or 8, as a terminal count
    function automatic logic [7:0] ratio_max(input logic [1:0] sel);
        ratio_max = (8'h01 << sel) - 8'h01;
    endfunction

    // full address compare; partial decode would alias other offsets
    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] b);
        addr_is = (a == b);
    endfunction

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    // zero wait states keeps the slave trivial
    assign setup = PSEL && !PENABLE;
    assign access = PSEL && PENABLE;
    assign rd_setup = setup && !PWRITE;
    assign hit_ctrl = addr_is(PADDR, `PFD_ADDR_CONTROL);
    assign hit_value = addr_is(PADDR, `PFD_ADDR_VALUE);
    assign hit_any = hit_ctrl || hit_value;
    assign wr_ctrl = access && PWRITE && hit_ctrl;

    // a stopped divider drops value writes without an error
    assign wr_value = access && PWRITE && hit_value && ctrl.enable; // RULE6

    // read data captured in setup so it stands through access
    assign next_rdata = hit_ctrl ? {28'h0, ctrl} :
                        hit_value ? {24'h0, divider_value} : 32'h0;
    assign next_prdata = rd_setup ? next_rdata : PRDATA;

    // error covers the whole access phase of an unmapped address
    assign next_pslverr = setup && !hit_any;

    // bus outputs; ready rises at the first edge after reset
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            PRDATA <= 32'h0;
            PSLVERR <= 1'b0;
            PREADY <= 1'b0;
        end
        else
        begin
            PRDATA <= next_prdata;
            PSLVERR <= next_pslverr;
            PREADY <= 1'b1;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // control register: enable, prescale, source
    assign next_ctrl = wr_ctrl ?
        pfd_pkg::pfd_ctrl_type'(PWDATA[3:0]) : ctrl; // RULE2 RULE4 RULE5

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            ctrl <= pfd_pkg::pfd_ctrl_type'(4'(`PFD_CONTROL_RESET));
        else
            ctrl <= next_ctrl;
    end

    // value register; the stop clear outranks any write
    assign next_divider_value = !ctrl.enable ? 8'h00 : // RULE7
                                wr_value ? PWDATA[7:0] : // RULE3
                                divider_value;

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            divider_value <= `PFD_VALUE_RESET;
        else
            divider_value <= next_divider_value;
    end

    // ----------------------------------------
    // source and prescaler
    // ----------------------------------------
    // source pulses stop and re-phase whenever the divider stops
    pfd_tick u_tick (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .run(ctrl.enable),
        .sel_slow(ctrl.src_slow), // RULE4
        .tick(src_tick)
    );

    // terminal count of the prescale stage
    assign pres_max = ratio_max(ctrl.prescale);
    assign pres_hit = src_tick && ({5'h0, pres_cnt} == pres_max); // RULE2

    // prescaler count and its one-cycle output pulse
    always_comb
    begin
        next_pres_cnt = pres_cnt;
        next_pres_tick = 1'b0;
        if (!ctrl.enable)
            next_pres_cnt = 3'h0;
        else if (pres_hit)
        begin
            next_pres_cnt = 3'h0;
            next_pres_tick = 1'b1; // RULE1
        end
        else if (src_tick)
            next_pres_cnt = pres_cnt + 3'h1;
    end

    // prescaler flops
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pres_cnt <= 3'h0;
            pres_tick <= 1'b0;
        end
        else
        begin
            pres_cnt <= next_pres_cnt;
            pres_tick <= next_pres_tick;
        end
    end

    // ----------------------------------------
    // run state
    // ----------------------------------------
    // first enabled cycle only arms the counter, so it starts clean
    always_comb
    begin
        next_state = state;
        unique case (state)
            pfd_pkg::PFD_IDLE:
                if (ctrl.enable)
                    next_state = pfd_pkg::PFD_RUN; // RULE5
            pfd_pkg::PFD_RUN:
                if (!ctrl.enable)
                    next_state = pfd_pkg::PFD_IDLE;
        endcase
    end

    // state flop
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            state <= pfd_pkg::PFD_IDLE;
        else
            state <= next_state;
    end

    // ----------------------------------------
    // general counter and output
    // ----------------------------------------
    // a new value at or below the count ends the current half period at the next prescale pulse
    assign running = (state == pfd_pkg::PFD_RUN) && ctrl.enable;
    assign cnt_hit = cnt >= divider_value;

    // toggle every N+1 prescale pulses; period is 2(N+1)
    always_comb
    begin
        next_cnt = cnt;
        next_wave = wave;
        if (!running)
        begin
            next_cnt = 8'h00;
            next_wave = 1'b0; // RULE10
        end
        else if (pres_tick && cnt_hit)
        begin
            next_cnt = 8'h00;
            next_wave = ~wave; // RULE8 RULE10
        end
        else if (pres_tick)
            next_cnt = cnt + 8'h01; // RULE1
    end

    // counter and toggle flops
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            cnt <= 8'h00;
            wave <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            wave <= next_wave;
        end
    end

    // ----------------------------------------
    // shared pin
    // ----------------------------------------
    // pin mux by fixed option; registered so the pin comes from a flop
    assign next_pin = PIN_MODE_DIVIDER ? wave : GPIO_OUT; // RULE9

    // costs one cycle of latency on both routes
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            PIN_OUT <= 1'b0;
        else
            PIN_OUT <= next_pin;
    end
endmodule
`default_nettype wire

// File: design/pfd_params.svh
// Purpose: constants for the programmable frequency divider
// Assumes: 40 MHz core clock, APB byte addressing
// Notes: offsets are byte addresses, index times four
`ifndef PFD_PARAMS_SVH
`define PFD_PARAMS_SVH
`define PFD_IDX_VALUE 8'h2f
`define PFD_IDX_CONTROL 8'h2e
`define PFD_ADDR_VALUE 12'h0bc
`define PFD_ADDR_CONTROL 12'h0b8
`define PFD_VALUE_RESET 8'h00
`define PFD_CONTROL_RESET 8'h00
`define PFD_BIT_ENABLE 0
`define PFD_BIT_PRESCALE_SELECT_BIT0 1
`define PFD_BIT_PRESCALE_SELECT_BIT1 2
`define PFD_BIT_SRC 3
`define PFD_CLK_HZ 40000000
`define PFD_FAST_HZ 895000
`define PFD_SLOW_HZ 32768
`define PFD_FAST_DIV (`PFD_CLK_HZ / `PFD_FAST_HZ)
`define PFD_SLOW_DIV (`PFD_CLK_HZ / `PFD_SLOW_HZ)
`endif

// File: design/pfd_pkg.sv
// Purpose: types for the programmable frequency divider
// Assumes: nothing
// Notes: control fields packed as a struct
package pfd_pkg;
    typedef struct packed {
        logic src_slow;
        logic [1:0] prescale;
        logic enable;
    } pfd_ctrl_type;
    typedef enum logic [0:0] {
        PFD_IDLE = 1'b0,
        PFD_RUN = 1'b1
    } pfd_state_type;
endpackage

// File: design/pfd_tick.sv
// Purpose: source clock enable generator
// Assumes: single core clock
// Notes: fractional accumulator keeps the average rate exact
`timescale 1ns/1ps
`default_nettype none
`include "pfd_params.svh"
module pfd_tick (
    input wire logic clk, // core clock
    input wire logic rst_n, // async reset
    input wire logic run, // counting allowed
    input wire logic sel_slow, // pick 32768 Hz source
    output logic tick // one-cycle source pulse
);
    logic [31:0] acc;
    logic [31:0] step;
    logic [32:0] sum;
    // ----------------------------------------
    // phase accumulator
    // ----------------------------------------
    // fast/slow step added against the core rate
    assign step = sel_slow ? 32'(`PFD_SLOW_HZ) : 32'(`PFD_FAST_HZ);
    assign sum = {1'b0, acc} + {1'b0, step};
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc <= 32'h0;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            acc <= 32'h0;
            tick <= 1'b0;
        end
        else if (sum[31:0] >= 32'(`PFD_CLK_HZ))
        begin
            acc <= sum[31:0] - 32'(`PFD_CLK_HZ);
            tick <= 1'b1;
        end
        else
        begin
            acc <= sum[31:0];
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: verification/pfd_properties.sv
// Purpose: port checks of the divider
// Assumes: register state mirrored from apb writes
// Notes: gap bounds allow for tick jitter
`timescale 1ns/1ps
`default_nettype none
`include "pfd_params.svh"
module pfd_properties (
    input wire logic CORE_CLK, // clock
    input wire logic NRST, // reset
    input wire logic PSEL, // select
    input wire logic PENABLE, // enable
    input wire logic PWRITE, // write
    input wire logic [11:0] PADDR, // address
    input wire logic [31:0] PWDATA, // wdata
    input wire logic [31:0] PRDATA, // rdata
    input wire logic PREADY, // ready
    input wire logic PSLVERR, // error
    input wire logic PIN_MODE_DIVIDER, // pin option
    input wire logic GPIO_OUT, // gpio level
    input wire logic PIN_OUT // pin
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    logic [3:0] ctl;
    logic [7:0] val;
    logic [31:0] gap;
    // decode of finished transfers
    wire is_c = PADDR == `PFD_ADDR_CONTROL;
    wire is_v = PADDR == `PFD_ADDR_VALUE;
    wire acc = PSEL && PENABLE && PREADY;
    wire wr = acc && PWRITE;
    wire rd = acc && !PWRITE;
    wire live = ctl[0] && PIN_MODE_DIVIDER;
    // slack covers tick jitter and pin latency
    wire [31:0] hi = (({24'h0, val} + 32'h1) << ctl[2:1]) * 32'd1222 + 32'd8;
    // mirror; gap restarts on any write or pin change
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ctl <= 4'h0;
            val <= 8'h0;
            gap <= 32'h0;
        end
        else
        begin
            if (wr && is_c)
                ctl <= PWDATA[3:0];
            if (wr && is_v && ctl[0])
                val <= PWDATA[7:0];
            else if (!ctl[0])
                val <= 8'h0;
            gap <= (wr || !live || $changed(PIN_OUT)) ? 32'h0 : gap + 32'h1;
        end
    end
    property p_err;
        PSEL && PENABLE |-> PSLVERR == !(is_c || is_v);
    endproperty
    a_err: assert property (p_err) else $error("slave error wrong");
    property p_ready;
        PSEL && PENABLE |-> PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("ready low in access");
    property p_rd_ctl;
        rd && is_c |-> PRDATA == {28'h0, ctl};
    endproperty
    a_rd_ctl: assert property (p_rd_ctl) else $error("control read");
    property p_rd_val;
        rd && is_v |-> PRDATA == {24'h0, val};
    endproperty
    a_rd_val: assert property (p_rd_val) else $error("value read");
    property p_ignore;
        wr && is_v && !ctl[0] ##[1:3] (rd && is_v) |-> PRDATA == 32'h0;
    endproperty
    a_ignore: assert property (p_ignore) else $error("write taken");
    property p_clear;
        rd && is_v && !ctl[0] |-> PRDATA == 32'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("value kept");
    property p_idle;
        (!ctl[0] && PIN_MODE_DIVIDER) [*8] |-> !PIN_OUT;
    endproperty
    a_idle: assert property (p_idle) else $error("pin not low");
    property p_hi;
        live |-> gap < hi;
    endproperty
    a_hi: assert property (p_hi) else $error("pin stuck");
    property p_gpio;
        !PIN_MODE_DIVIDER && $past(!PIN_MODE_DIVIDER) && $past(NRST)
            |-> PIN_OUT == $past(GPIO_OUT);
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio pin");
    c_run: cover property (live && $changed(PIN_OUT));
    c_err: cover property (PSLVERR);
    c_gpio: cover property (!PIN_MODE_DIVIDER && $changed(PIN_OUT));
endmodule
`default_nettype wire

// File: verification/pfd_top_tb.sv
// Purpose: self-checking bench for the divider
// Assumes: zero wait apb slave
// Notes: half periods counted in core cycles
`timescale 1ns/1ps
`default_nettype none
`include "pfd_params.svh"
module pfd_top_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] pad = 12'h0;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic prdy;
    logic perr;
    logic mode = 1'b1;
    logic gpio = 1'b0;
    logic pin;
    logic [31:0] rd;
    logic er;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    pfd_top uut (.CORE_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pad), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(prdy), .PSLVERR(perr), .PIN_MODE_DIVIDER(mode),
        .GPIO_OUT(gpio), .PIN_OUT(pin));
    // 40 MHz core clock
    always #12.5 clk = ~clk;
    // hang guard, well above the run length
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pad <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // third interval, the first two may be irregular
    task automatic half(output int n);
        logic p;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            p = pin;
            while (pin === p)
            begin
                n++;
                @(posedge clk);
            end
        end
    endtask
    task automatic t_regs;
        apb(1'b0, `PFD_ADDR_CONTROL, 32'h0);
        chk("ctl", rd, 32'h0);
        apb(1'b1, `PFD_ADDR_VALUE, 32'h5a);
        apb(1'b0, `PFD_ADDR_VALUE, 32'h0);
        chk("val off", rd, 32'h0);
        apb(1'b0, 12'h0c0, 32'h0);
        chk("err", {31'h0, er}, 32'h1);
        chk("unmapped", rd, 32'h0);
    endtask
    task automatic t_gpio;
        mode <= 1'b0;
        gpio <= 1'b1;
        repeat (3) @(posedge clk);
        chk("gpio", {31'h0, pin}, 32'h1);
        gpio <= 1'b0;
        mode <= 1'b1;
    endtask
    task automatic t_div(input logic [1:0] p, input logic s, input logic [7:0] n);
        int b;
        int h;
        b = (n + 1) << p;
        apb(1'b1, `PFD_ADDR_CONTROL, {28'h0, s, p, 1'b1});
        apb(1'b1, `PFD_ADDR_VALUE, {24'h0, n});
        apb(1'b0, `PFD_ADDR_VALUE, 32'h0);
        chk("val", rd, {24'h0, n});
        apb(1'b0, `PFD_ADDR_CONTROL, 32'h0);
        chk("ctl", rd, {28'h0, s, p, 1'b1});
        half(h);
        chk("half", h >= b * (s ? 1220 : 44) && h <= b * (s ? 1221 : 45) + 1, 1);
        apb(1'b1, `PFD_ADDR_CONTROL, 32'h0);
        apb(1'b0, `PFD_ADDR_VALUE, 32'h0);
        chk("cleared", rd, 32'h0);
        repeat (8) @(posedge clk);
        chk("idle", {31'h0, pin}, 32'h0);
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_gpio();
        for (int p = 0; p < 4; p++)
            t_div(p[1:0], 1'b0, 8'(p + 1));
        t_div(2'h0, 1'b1, 8'h0);
        end_of_test();
    end
endmodule
bind pfd_top pfd_properties chk_i (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PIN_MODE_DIVIDER(PIN_MODE_DIVIDER), .GPIO_OUT(GPIO_OUT), .PIN_OUT(PIN_OUT));
`default_nettype wire
